// >>> ppdg_map.svh
`ifndef PPDG_MAP_SVH
`define PPDG_MAP_SVH
`define PPDG_ADDR_PERIOD 8'h00
`define PPDG_ADDR_DUTY_HIGH 8'h04
`define PPDG_ADDR_CONTROL 8'h08
`define PPDG_ADDR_ACTIVE 8'h0C
`define PPDG_ADDR_STATUS 8'h10
`define PPDG_CTL_ENABLE 0
`define PPDG_CTL_PRESC_LO 2
`define PPDG_CTL_PRESC_HI 3
`define PPDG_CTL_DCB_LO 4
`define PPDG_CTL_DCB_HI 5
`define PPDG_RST_PERIOD 8'hFF
`define PPDG_RST_DUTY 8'h00
`define PPDG_PHASES 4
`endif

// >>> ppdg_pkg.sv
package ppdg_pkg;
  typedef enum logic [1:0] {
    ppdg_pre_1,
    ppdg_pre_4,
    ppdg_pre_16,
    ppdg_pre_16b
  } ppdg_presc_t;
endpackage : ppdg_pkg

// >>> ppdg_prescaler.sv
`timescale 1ns/1ps
`include "ppdg_map.svh"
// produces a 2-bit sub-count and a tick each time the timebase advances one of its 10 bits
module ppdg_prescaler (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire ppdg_pkg::ppdg_presc_t ratio,
  output logic [1:0] sub_bits,
  output logic sub_tick
);
  logic [5:0] pcount;
  logic [5:0] sub_len;

  // ratio 1:1 advances the low bits every clock (clock phase), else every ratio clocks
  always_comb begin
    unique case (ratio)
      ppdg_pkg::ppdg_pre_1: sub_len = 6'h00;
      ppdg_pkg::ppdg_pre_4: sub_len = 6'h03;
      default: sub_len = 6'h0F;
    endcase
  end

  // tick marks the edge at which sub_bits advances, so the counter steps on the same edge
  // as the low bits wrap and the 10-bit timebase never shows a skewed value
  assign sub_tick = run && !sys_rst && (pcount >= sub_len);

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      pcount <= 6'h00;
      sub_bits <= 2'h0;
    end else begin
      if (pcount >= sub_len) begin
        pcount <= 6'h00;
        sub_bits <= sub_bits + 2'h1;
      end else begin
        pcount <= pcount + 6'h01;
      end
    end
  end
endmodule : ppdg_prescaler

// >>> ppdg_pwm.sv
`timescale 1ns/1ps
`include "ppdg_map.svh"
module ppdg_pwm (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic pwm_output_pin
);
  logic [7:0] period_limit;
  logic [7:0] duty_high_write;
  logic [1:0] duty_low_bits;
  logic pwm_enable;
  ppdg_pkg::ppdg_presc_t presc_ratio;
  logic [7:0] duty_active_buffer;
  logic [1:0] duty_latch;
  logic [7:0] base_counter;
  logic [1:0] sub_bits;
  logic sub_tick;
  logic restart_pend;
  logic [9:0] timebase;
  logic [9:0] duty_active;
  logic [9:0] duty_pending;
  logic req;
  logic wr;
  logic hit_period;
  logic hit_duty;
  logic hit_ctrl;
  logic hit_active;
  logic hit_status;
  logic mapped;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign hit_period = wb_adr_i[7:0] == `PPDG_ADDR_PERIOD;
  assign hit_duty = wb_adr_i[7:0] == `PPDG_ADDR_DUTY_HIGH;
  assign hit_ctrl = wb_adr_i[7:0] == `PPDG_ADDR_CONTROL;
  assign hit_active = wb_adr_i[7:0] == `PPDG_ADDR_ACTIVE;
  assign hit_status = wb_adr_i[7:0] == `PPDG_ADDR_STATUS;
  assign mapped = (wb_adr_i[31:8] == 24'h000000)
    && (hit_period || hit_duty || hit_ctrl || hit_active || hit_status);

  // 10-bit timebase from the counter and the two phase/prescaler bits
  assign timebase = {base_counter, sub_bits};
  assign duty_active = {duty_active_buffer, duty_latch};
  assign duty_pending = {duty_high_write, duty_low_bits};

  // single-cycle answer; unmapped addresses answer with err
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req) begin
      wb_dat_o <= 32'h00000000;
      if (hit_period) wb_dat_o[7:0] <= period_limit;
      if (hit_duty) wb_dat_o[7:0] <= duty_high_write;
      if (hit_ctrl) begin
        wb_dat_o[`PPDG_CTL_ENABLE] <= pwm_enable;
        wb_dat_o[`PPDG_CTL_PRESC_HI:`PPDG_CTL_PRESC_LO] <= presc_ratio;
        wb_dat_o[`PPDG_CTL_DCB_HI:`PPDG_CTL_DCB_LO] <= duty_low_bits;
      end
      if (hit_active) wb_dat_o[7:0] <= duty_active_buffer;
      if (hit_status) begin
        wb_dat_o[7:0] <= base_counter;
        wb_dat_o[8] <= pwm_output_pin;
      end
    end
  end

  // software registers, writable at any time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      period_limit <= `PPDG_RST_PERIOD;
      duty_high_write <= `PPDG_RST_DUTY;
      duty_low_bits <= 2'h0;
      pwm_enable <= 1'b0;
      presc_ratio <= ppdg_pkg::ppdg_pre_1;
    end else if (wr) begin
      if (hit_period) period_limit <= wb_dat_i[7:0];
      if (hit_duty) duty_high_write <= wb_dat_i[7:0];
      if (hit_ctrl) begin
        pwm_enable <= wb_dat_i[`PPDG_CTL_ENABLE];
        presc_ratio <= ppdg_pkg::ppdg_presc_t'(wb_dat_i[`PPDG_CTL_PRESC_HI:`PPDG_CTL_PRESC_LO]);
        duty_low_bits <= wb_dat_i[`PPDG_CTL_DCB_HI:`PPDG_CTL_DCB_LO];
      end
    end
  end

  ppdg_prescaler u_presc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(pwm_enable),
    .ratio(presc_ratio),
    .sub_bits(sub_bits),
    .sub_tick(sub_tick)
  );

  // base_counter advances when the 2 low bits wrap: period = (limit+1)*4*ratio
  always_ff @(posedge mclk) begin
    if (sys_rst || !pwm_enable) begin
      base_counter <= 8'h00;
      restart_pend <= 1'b0;
    end else begin
      restart_pend <= 1'b0;
      if (sub_tick && sub_bits == 2'h3) begin
        if (base_counter == period_limit) begin
          base_counter <= 8'h00;
          restart_pend <= 1'b1;
        end else begin
          base_counter <= base_counter + 8'h01;
        end
      end
    end
  end

  // active buffer loads at restart and on every clock while disabled; bus writes to it are dropped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      duty_active_buffer <= `PPDG_RST_DUTY;
      duty_latch <= 2'h0;
    end else if (restart_pend || !pwm_enable) begin
      duty_active_buffer <= duty_high_write;
      duty_latch <= duty_low_bits;
    end
  end

  // restart uses the freshly latched pending value, so a zero duty never raises the pin
  always_ff @(posedge mclk) begin
    if (sys_rst || !pwm_enable) begin
      pwm_output_pin <= 1'b0;
    end else if (restart_pend) begin
      pwm_output_pin <= duty_pending != 10'h000;
    end else if (timebase == duty_active) begin
      pwm_output_pin <= 1'b0;
    end
  end
endmodule : ppdg_pwm

// >>> ppdg_pwm_props.sv
`timescale 1ns/1ps
module ppdg_pwm_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic pwm_output_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire req = wb_cyc_i && wb_stb_i;
  property p_answer; req && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_no_spur; wb_ack_o || wb_err_o |-> $past(req); endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without request");
  property p_err_map; wb_err_o |-> !(wb_adr_i inside {0, 4, 8, 12, 16}); endproperty
  a_err_map: assert property (p_err_map) else $error("err on mapped address");
  property p_dat_hold; !req |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_wake; $fell(sys_rst) |-> !pwm_output_pin ##1 !pwm_output_pin; endproperty
  a_wake: assert property (p_wake) else $error("pin high after reset");
  property p_spacing; $rose(pwm_output_pin) |=> (!$rose(pwm_output_pin))[*3]; endproperty
  a_spacing: assert property (p_spacing) else $error("period too short");
  property p_excl; !(wb_ack_o && wb_err_o); endproperty
  a_excl: assert property (p_excl) else $error("ack with err");
endmodule : ppdg_pwm_chk
bind ppdg_pwm ppdg_pwm_chk chk_u (.mclk, .sys_rst, .wb_adr_i, .wb_dat_o, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_err_o, .pwm_output_pin);

// >>> ppdg_pwm_bench.sv
`timescale 1ns/1ps
module ppdg_pwm_bench;
  logic mclk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, wb_err_o, pwm_output_pin, e;
  int failures = 0, n_compared = 0, per, hi;
  ppdg_pwm dut_u (.mclk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i(4'hF), .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .pwm_output_pin);
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("Error %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // the extra leading edge guarantees one idle cycle between requests
  task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge mclk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  // skips to a clean restart so a period mixing old and new settings is never counted
  task automatic measure;
    hi = 0;
    do @(posedge mclk); while (pwm_output_pin !== 1'b0);
    do @(posedge mclk); while (pwm_output_pin !== 1'b1);
    do begin @(posedge mclk); hi++; end while (pwm_output_pin === 1'b1);
    per = hi;
    do begin @(posedge mclk); per++; end while (pwm_output_pin !== 1'b1);
  endtask : measure
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(32'h10, 32'h0, 1'b0);
    chk(q, 32'h0);
    chk(e, 1'b0);
    bus(32'h0, 32'h0, 1'b0);
    chk(q, 32'hFF);
    bus(32'h14, 32'h0, 1'b0);
    chk(e, 1'b1);
    $display("reset and map test done");
    for (int r = 0; r < 3; r++) begin
      bus(32'h0, 32'h3, 1'b1);
      bus(32'h4, 32'h2, 1'b1);
      bus(32'h8, 32'h1 | (r << 2), 1'b1);
      bus(32'hC, 32'hFF, 1'b1);
      measure();
      chk(per, 16 << (2 * r));
      chk(hi, 8 << (2 * r));
    end
    $display("prescale test done");
    bus(32'h4, 32'h1, 1'b1);
    bus(32'h8, 32'h31, 1'b1);
    measure();
    chk(hi, 7);
    $display("low bits test done");
    bus(32'h4, 32'h0, 1'b1);
    bus(32'h8, 32'h1, 1'b1);
    repeat (40) @(posedge mclk);
    hi = 0;
    repeat (32) begin
      @(posedge mclk);
      hi += (pwm_output_pin !== 1'b0);
    end
    chk(hi, 0);
    $display("zero duty test done");
    print_verdict();
  end
endmodule : ppdg_pwm_bench
